// ==== rtl/kltcc_defines.svh ====
// Register offsets, field positions, reset values for the training control bank.
`ifndef KLTCC_DEFINES_SVH
`define KLTCC_DEFINES_SVH
`define KLTCC_ADDR_W        8
`define KLTCC_OFF_CTRL      8'hd0
`define KLTCC_OFF_STROBES   8'hd1
`define KLTCC_OFF_STATUS    8'hd2
`define KLTCC_OFF_UPDATE    8'hd4
`define KLTCC_OFF_IRQ_STAT  8'hf0
`define KLTCC_OFF_IRQ_MASK  8'hf1
`define KLTCC_OFF_EQ_L1     8'he1
`define KLTCC_OFF_EQ_L2     8'he5
`define KLTCC_OFF_EQ_L3     8'he9
`define KLTCC_BIT_PART_OVR  16
`define KLTCC_BIT_LOC_OVR   17
`define KLTCC_BIT_SEND0     4
`define KLTCC_BIT_SEND1     5
`define KLTCC_BIT_APPLY1    9
`define KLTCC_EQ_LSB        16
`define KLTCC_EQ_W          8
`define KLTCC_UPD_W         6
`define KLTCC_STAT_W        6
`define KLTCC_LANE_STRIDE   8
`define KLTCC_RST_EQ        8'h00
`define KLTCC_RST_UPD       6'h00
`define KLTCC_IRQ_W         7
`endif

// ==== rtl/kltcc_pkg.sv ====
// Types shared by the training control bank.
package kltcc_pkg;
    typedef logic [1:0] kltcc_req_t;
    localparam kltcc_req_t KLTCC_REQ_HOLD = 2'h0;
    localparam kltcc_req_t KLTCC_REQ_INC  = 2'h1;
    localparam kltcc_req_t KLTCC_REQ_DEC  = 2'h2;
endpackage

// ==== rtl/kltcc_regs.sv ====
// Register bank for four-lane link training coefficient control.
`include "kltcc_defines.svh"

// Behaviour
// - Bits 6 and 7 are self-clearing send strobes for lanes 2 and 3, like bit 5 for lane 1.
// - Writing 1 to bit 9 loads lane 1 local equalizer settings from 0xE1 bits 23 to 16.
// - Writing 1 to bit 10 loads lane 2 local equalizer settings from 0xE5 bits 23 to 16.
// - Writing 1 to bit 11 loads lane 3 local equalizer settings from 0xE9 bits 23 to 16.
// - Apply strobes clear themselves and writing 0 changes nothing.
// - Apply strobes do nothing unless the local override enable at bit 17 is set.
// - Status bits 13:8, 21:16 and 29:24 report lanes 1 to 3 as bits 5:0 do for lane 0.
// - The update field bits 5:0 show the word sent on all four lanes.
// - The update field is writable only while the partner override enable is set.
// - The field holds post, main and pre requests of two bits: 01 up, 10 down, 00 hold.
// - A send strobe with partner override enabled starts sending the software word.
// - Partner override set lets software pick the sent requests, else the training logic does.
// - Local override clear follows partner requests, set takes software values on lanes 1 to 3 and holds lane 0.
module kltcc_regs
    import kltcc_pkg::*;
(
    input  wire logic                       ref_clk,
    input  wire logic                       rst_b,
    input  wire logic [`KLTCC_ADDR_W-1:0]   addr,
    input  wire logic [31:0]                wdata,
    input  wire logic                       wr_en,
    input  wire logic                       rd_en,
    output logic      [31:0]                rdata,
    input  wire logic [4*`KLTCC_STAT_W-1:0] lane_status,
    input  wire logic [`KLTCC_UPD_W-1:0]    link_training_update,
    input  wire logic [4*`KLTCC_EQ_W-1:0]   partner_eq,
    input  wire logic [3:0]                 partner_eq_valid,
    output logic      [4*`KLTCC_UPD_W-1:0]  tx_update_word,
    output logic      [3:0]                 tx_update_send,
    output logic      [4*`KLTCC_EQ_W-1:0]   local_eq,
    output logic      [3:0]                 local_eq_load,
    output logic                            partner_coef_override_en,
    output logic                            local_coef_override_en,
    output logic                            irq
);

    logic [`KLTCC_UPD_W-1:0]  sw_update;
    logic [3*`KLTCC_EQ_W-1:0] eq_field;
    logic [`KLTCC_IRQ_W-1:0]  irq_stat;
    logic [`KLTCC_IRQ_W-1:0]  irq_mask;

    wire wr_ctrl  = wr_en && (addr == `KLTCC_OFF_CTRL);
    wire wr_strb  = wr_en && (addr == `KLTCC_OFF_STROBES);
    wire wr_upd   = wr_en && (addr == `KLTCC_OFF_UPDATE);
    wire wr_istat = wr_en && (addr == `KLTCC_OFF_IRQ_STAT);
    wire wr_imask = wr_en && (addr == `KLTCC_OFF_IRQ_MASK);

    function automatic logic [`KLTCC_ADDR_W-1:0] eq_off(input int lane);
        case (lane)
            1:       eq_off = `KLTCC_OFF_EQ_L1;
            2:       eq_off = `KLTCC_OFF_EQ_L2;
            default: eq_off = `KLTCC_OFF_EQ_L3;
        endcase
    endfunction

    // Send strobes: lanes 0..3 at bits 4..7; only act when override is on.
    wire [3:0] send_req = wr_strb ? wdata[`KLTCC_BIT_SEND0 +: 4] : 4'h0;
    wire [3:0] next_send = partner_coef_override_en ? send_req : 4'h0;
    // Apply strobes: lanes 1..3 at bits 9..11.
    wire [2:0] apply_req = wr_strb ? wdata[`KLTCC_BIT_APPLY1 +: 3] : 3'h0;
    wire [2:0] next_apply = local_coef_override_en ? apply_req : 3'h0;

    // Sent word follows the training logic unless software owns it.
    wire [`KLTCC_UPD_W-1:0] cur_update =
        partner_coef_override_en ? sw_update : link_training_update;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            partner_coef_override_en <= 1'b0;
            local_coef_override_en   <= 1'b0;
        end
        else if (wr_ctrl)
        begin
            partner_coef_override_en <= wdata[`KLTCC_BIT_PART_OVR];
            local_coef_override_en   <= wdata[`KLTCC_BIT_LOC_OVR];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            sw_update <= `KLTCC_RST_UPD;
        else if (wr_upd && partner_coef_override_en)
            sw_update <= wdata[`KLTCC_UPD_W-1:0];
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_update_send <= 4'h0;
            tx_update_word <= '0;
        end
        else
        begin
            tx_update_send <= next_send;
            tx_update_word <= {4{cur_update}};
        end
    end

    genvar g;
    generate
        for (g = 1; g < 4; g++)
        begin : g_lane
            localparam int I = g - 1;
            wire wr_eq = wr_en && (addr == eq_off(g));
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                    eq_field[I*`KLTCC_EQ_W +: `KLTCC_EQ_W] <= `KLTCC_RST_EQ;
                else if (wr_eq)
                    eq_field[I*`KLTCC_EQ_W +: `KLTCC_EQ_W] <=
                        wdata[`KLTCC_EQ_LSB +: `KLTCC_EQ_W];
            end
            // Local equalizer: software value on apply, else partner request while local override is clear.
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                begin
                    local_eq[g*`KLTCC_EQ_W +: `KLTCC_EQ_W] <= `KLTCC_RST_EQ;
                    local_eq_load[g] <= 1'b0;
                end
                else if (next_apply[I])
                begin
                    local_eq[g*`KLTCC_EQ_W +: `KLTCC_EQ_W] <=
                        eq_field[I*`KLTCC_EQ_W +: `KLTCC_EQ_W];
                    local_eq_load[g] <= 1'b1;
                end
                else if (!local_coef_override_en && partner_eq_valid[g])
                begin
                    local_eq[g*`KLTCC_EQ_W +: `KLTCC_EQ_W] <=
                        partner_eq[g*`KLTCC_EQ_W +: `KLTCC_EQ_W];
                    local_eq_load[g] <= 1'b1;
                end
                else
                    local_eq_load[g] <= 1'b0;
            end
        end
    endgenerate

    // Lane 0 equalizer follows the partner unless local override holds it.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            local_eq[`KLTCC_EQ_W-1:0] <= `KLTCC_RST_EQ;
            local_eq_load[0] <= 1'b0;
        end
        else
        begin
            local_eq_load[0] <= !local_coef_override_en && partner_eq_valid[0];
            if (!local_coef_override_en && partner_eq_valid[0])
                local_eq[`KLTCC_EQ_W-1:0] <= partner_eq[`KLTCC_EQ_W-1:0];
        end
    end

    // Events: send issued (4), apply issued (3). Set wins over clear.
    wire [`KLTCC_IRQ_W-1:0] irq_ev = {next_apply, next_send};
    wire [`KLTCC_IRQ_W-1:0] irq_clr = wr_istat ? wdata[`KLTCC_IRQ_W-1:0] : '0;

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            irq_stat <= '0;
            irq_mask <= '0;
            irq      <= 1'b0;
        end
        else
        begin
            irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
            if (wr_imask)
                irq_mask <= wdata[`KLTCC_IRQ_W-1:0];
            irq <= |(((irq_stat & ~irq_clr) | irq_ev) &
                     (wr_imask ? wdata[`KLTCC_IRQ_W-1:0] : irq_mask));
        end
    end

    // Status register: four lanes of six bits on an eight-bit stride.
    logic [31:0] status_word;
    always_comb
    begin
        status_word = '0;
        for (int l = 0; l < 4; l++)
            status_word[l*`KLTCC_LANE_STRIDE +: `KLTCC_STAT_W] =
                lane_status[l*`KLTCC_STAT_W +: `KLTCC_STAT_W];
    end

    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0;
        case (addr)
            `KLTCC_OFF_CTRL:
            begin
                rd_mux[`KLTCC_BIT_PART_OVR] = partner_coef_override_en;
                rd_mux[`KLTCC_BIT_LOC_OVR]  = local_coef_override_en;
            end
            `KLTCC_OFF_STROBES: rd_mux = 32'h0;
            `KLTCC_OFF_STATUS:  rd_mux = status_word;
            `KLTCC_OFF_UPDATE:  rd_mux[`KLTCC_UPD_W-1:0] = cur_update;
            `KLTCC_OFF_EQ_L1:
                rd_mux[`KLTCC_EQ_LSB +: `KLTCC_EQ_W] = eq_field[7:0];
            `KLTCC_OFF_EQ_L2:
                rd_mux[`KLTCC_EQ_LSB +: `KLTCC_EQ_W] = eq_field[15:8];
            `KLTCC_OFF_EQ_L3:
                rd_mux[`KLTCC_EQ_LSB +: `KLTCC_EQ_W] = eq_field[23:16];
            `KLTCC_OFF_IRQ_STAT: rd_mux[`KLTCC_IRQ_W-1:0] = irq_stat;
            `KLTCC_OFF_IRQ_MASK: rd_mux[`KLTCC_IRQ_W-1:0] = irq_mask;
            default:            rd_mux = 32'h0;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            rdata <= 32'h0;
        else
            rdata <= rd_en ? rd_mux : 32'h0;
    end

endmodule

// ==== dv/kltcc_chk.sv ====
// Concurrent checks on the ports of the training control bank.
module kltcc_chk (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr_en,
    input wire logic        rd_en,
    input wire logic [31:0] rdata,
    input wire logic [23:0] lane_status,
    input wire logic [5:0]  link_training_update,
    input wire logic [3:0]  partner_eq_valid,
    input wire logic [23:0] tx_update_word,
    input wire logic [3:0]  tx_update_send,
    input wire logic [3:0]  local_eq_load,
    input wire logic        partner_coef_override_en,
    input wire logic        local_coef_override_en
);
    wire logic        stb = wr_en && addr == 8'hd1;
    wire logic        ctl = wr_en && addr == 8'hd0;
    wire logic [31:0] stat = {2'h0, lane_status[23:18], 2'h0,
        lane_status[17:12], 2'h0, lane_status[11:6], 2'h0, lane_status[5:0]};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_send_pulse: assert property (
        stb && partner_coef_override_en |=> tx_update_send == $past(wdata[7:4]))
        else $error("send pulse wrong");
    a_send_blocked: assert property (
        !(stb && partner_coef_override_en) |=> tx_update_send == 4'h0)
        else $error("send pulse without cause");
    a_apply_load: assert property (
        stb && local_coef_override_en |=>
        local_eq_load == {$past(wdata[11:9]), 1'b0}) else $error("apply wrong");
    a_apply_ignored: assert property (
        !local_coef_override_en |=> local_eq_load == $past(partner_eq_valid))
        else $error("load not from partner");
    a_word_follow: assert property (
        !partner_coef_override_en |=>
        tx_update_word == {4{$past(link_training_update)}})
        else $error("sent word not from training logic");
    a_status_read: assert property (
        rd_en && addr == 8'hd2 |=> rdata == $past(stat))
        else $error("status read wrong");
    a_read_once: assert property (
        rdata != 32'h0 |-> $past(rd_en)) else $error("read data not cleared");
    a_ctrl_write: assert property (
        ctl |=> partner_coef_override_en == $past(wdata[16]) &&
        local_coef_override_en == $past(wdata[17])) else $error("ctrl wrong");
endmodule
bind kltcc_regs kltcc_chk i_chk (.ref_clk, .rst_b, .addr, .wdata, .wr_en,
    .rd_en, .rdata, .lane_status, .link_training_update, .partner_eq_valid,
    .tx_update_word, .tx_update_send, .local_eq_load,
    .partner_coef_override_en, .local_coef_override_en);

// ==== dv/kltcc_partner.sv ====
// Link partner model: answers each send request with an equalizer request.
module kltcc_partner (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic [3:0]  tx_update_send,
    input  wire logic [23:0] tx_update_word,
    output logic      [31:0] partner_eq,
    output logic      [3:0]  partner_eq_valid
);
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            partner_eq_valid <= 4'h0;
        else
            partner_eq_valid <= tx_update_send;
    end
    // The request lines toggle while no request is valid.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            partner_eq <= 32'h0;
        else
            partner_eq <= (tx_update_send != 4'h0) ?
                {4{2'h0, tx_update_word[5:0]}} : ~partner_eq;
    end
endmodule

// ==== dv/tb_kr4_link_training_coef_ctrl.sv ====
// Self-checking bench for the training control bank.
module tb_kr4_link_training_coef_ctrl
    import kltcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk, rst_b, wr_en, rd_en, irq;
    logic        partner_coef_override_en, local_coef_override_en;
    logic [7:0]  addr;
    logic [5:0]  link_training_update, w;
    logic [3:0]  partner_eq_valid, tx_update_send, local_eq_load;
    logic [23:0] lane_status, tx_update_word;
    logic [31:0] wdata, rdata, partner_eq, local_eq, r, seed;
    int          num_errors, checked, exp_eq[4];
    kltcc_req_t  cd[3] = '{KLTCC_REQ_INC, KLTCC_REQ_DEC, KLTCC_REQ_HOLD};
    kltcc_regs i_dut (.ref_clk, .rst_b, .addr, .wdata, .wr_en, .rd_en,
        .rdata, .lane_status, .link_training_update, .partner_eq,
        .partner_eq_valid, .tx_update_word, .tx_update_send, .local_eq,
        .local_eq_load, .partner_coef_override_en, .local_coef_override_en,
        .irq);
    kltcc_partner i_lp (.ref_clk, .rst_b, .tx_update_send, .tx_update_word,
        .partner_eq, .partner_eq_valid);
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic chk(input string n, input logic [31:0] e, g);
        checked++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", n, e, g);
            num_errors++;
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr_en <= wr;
        rd_en <= !wr;
        addr  <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        #1;
    endtask
    task automatic complete_run();
        if (num_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        {rst_b, wr_en, rd_en, addr, wdata, lane_status} = '0;
        seed = 32'heb60ab89;
        r = rnd();
        link_training_update = r[29:24];
        lane_status = r[23:0];
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        bus(0, 8'hd2, 0);
        chk("status", {2'h0, r[23:18], 2'h0, r[17:12], 2'h0, r[11:6], 2'h0,
            r[5:0]}, rdata);
        bus(1, 8'h33, '1);
        bus(0, 8'h33, 0);
        chk("unmapped", 0, rdata);
        bus(1, 8'hd4, 32'h15);
        bus(1, 8'hd1, 32'hef0);
        bus(0, 8'hd4, 0);
        chk("update_ro", {26'h0, r[29:24]}, rdata);
        chk("local_eq", 0, local_eq);
        bus(1, 8'hd0, 32'h10000);
        for (int c = 0; c < 3; c++)
        begin
            w = {cd[c], cd[(c + 1) % 3], cd[(c + 2) % 3]};
            bus(1, 8'hd4, {26'h0, w});
            bus(0, 8'hd4, 0);
            chk("update", {26'h0, w}, rdata);
            bus(1, 8'hd1, 32'h10 << (c + 1));
            repeat (2) @(posedge ref_clk);
            #1;
            exp_eq[c + 1] = w;
            chk("tx_word", {4{w}}, {8'h0, tx_update_word});
            chk("eq", exp_eq[c + 1], local_eq[8 * (c + 1) +: 8]);
        end
        chk("irq", 0, irq);
        bus(1, 8'hf1, 32'h4);
        @(posedge ref_clk);
        #1;
        chk("irq", 1, irq);
        bus(0, 8'hf0, 0);
        chk("irq_stat", 32'he, rdata);
        bus(1, 8'hf0, 32'he);
        @(posedge ref_clk);
        #1;
        chk("irq", 0, irq);
        bus(1, 8'hd0, 32'h30000);
        for (int l = 1; l < 4; l++)
        begin
            r = rnd();
            exp_eq[l] = r[7:0];
            bus(1, 8'he1 + 8'(4 * (l - 1)), {8'h0, r[7:0], 16'h0});
            bus(1, 8'hd1, 32'h100 << l);
            chk("apply", 32'h1 << l, local_eq_load);
        end
        for (int l = 0; l < 4; l++)
            chk("eq", exp_eq[l], local_eq[8 * l +: 8]);
        complete_run();
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        complete_run();
    end
endmodule
